// File: acg_pad_model.sv
// Pad model: resolves each general pin from both parties' drivers
module acg_pad_model (
  // Drivers
  input wire logic [1:0] oe_n_i,
  input wire logic [1:0] out_i,
  input wire logic [1:0] ext_i,
  // Resolved level
  output logic [1:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Design wins while its enable is low, else the outside source
  assign pad_o = (oe_n_i & ext_i) | (~oe_n_i & out_i);
endmodule

// File: acg_pkg.sv
// Package: register map, field layout and carrier types for the bank
package acg_pkg;

  // Register bus widths, channel count and channel index width
  localparam int ACG_ADDR_W = 8;
  localparam int ACG_DATA_W = 16;
  localparam int ACG_NUM_CH = 16;
  localparam int ACG_CH_IDX_W = 4;

  // Register offsets (word index on the plain register port)
  localparam logic [7:0] ACG_OFS_PIN_CTRL = 8'h06;
  localparam logic [7:0] ACG_OFS_IDENT = 8'h07;
  localparam logic [7:0] ACG_OFS_CH_FIRST = 8'h10;
  localparam logic [7:0] ACG_OFS_CH_LAST = 8'h1F;

  // Pin control field positions
  localparam int ACG_POS_PIN1_IN_EN = 5;
  localparam int ACG_POS_PIN0_IN_EN = 4;
  localparam int ACG_POS_PIN1_OUT_EN = 3;
  localparam int ACG_POS_PIN0_OUT_EN = 2;
  localparam int ACG_POS_PIN1_LEVEL = 1;
  localparam int ACG_POS_PIN0_LEVEL = 0;

  // Channel register field positions
  localparam int ACG_POS_CH_ENABLE = 15;
  localparam int ACG_POS_SETUP_HI = 14;
  localparam int ACG_POS_SETUP_LO = 12;
  localparam int ACG_POS_PAIR_HI = 9;
  localparam int ACG_POS_PAIR_LO = 0;

  // Reset values and input pair codes
  localparam logic [15:0] ACG_RST_CHANNEL = 16'h8001;
  localparam logic [5:0] ACG_RST_PIN_CTRL = 6'h00;
  localparam logic [9:0] ACG_PAIR_IN0_IN1 = 10'h001;
  localparam logic [9:0] ACG_PAIR_IN0_COMMON = 10'h010;

  // Identifier; the value is arbitrary, low nibble carries no meaning
  localparam logic [15:0] ACG_IDENT_DEFAULT = 16'h5A50;

  // Per-pin control as held in the pin control register
  typedef struct packed {
    logic input_enable;
    logic output_enable;
    logic level;
  } acg_pin_cfg_t;

  // One channel configuration register
  typedef struct packed {
    logic channel_enable;
    logic [2:0] setup_select;
    logic [1:0] reserved;
    logic [9:0] input_pair_select;
  } acg_chan_cfg_t;

  // Selection handed to the conversion engine
  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [2:0] setup_select;
    logic [9:0] input_pair_select;
  } acg_conv_sel_t;

endpackage

// File: acg_regs.sv
// Top module: pin control, identifier and channel registers with sequencer
//
// The address-and-strobe port was chosen for this implementation.

// Functional notes
// - Bit 5 makes pin 1 an input
// - Bit 4 makes pin 0 an input
// - Bit 3 drives pin 1 as output
// - Bit 2 drives pin 0 as output
// - Bit 1 is pin 1 level or readback
// - Bit 0 is pin 0 level or readback
// - Identifier register is read-only fixed code
// - Sixteen channel registers, reset 0x8001
// - Bit 15 enables; enabled channels sequenced
// - Bits 14:12 pick one of eight setups
// - A setup's four registers apply together
// - Bits 9:0 pick the analog input pair
module acg_regs #(
  parameter logic [15:0] IDENT_CODE = acg_pkg::ACG_IDENT_DEFAULT,
  parameter int NUM_CH = acg_pkg::ACG_NUM_CH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [acg_pkg::ACG_ADDR_W-1:0] reg_addr_i,
  input wire logic [acg_pkg::ACG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [acg_pkg::ACG_DATA_W-1:0] reg_rdata_o,
  // General pins, split into input, output and active-low enable
  input wire logic [1:0] general_pin_in_i,
  output logic [1:0] general_pin_out_o,
  output logic [1:0] general_pin_oe_n_o,
  // Conversion engine side
  input wire logic conv_done_i,
  output acg_pkg::acg_conv_sel_t conv_sel_o,
  output logic [NUM_CH-1:0] channel_enable_o
);
  import acg_pkg::*;

  // Synchronised reset
  logic reset_meta_n;
  logic reset_sync_n;

  // Pin control register state
  acg_pin_cfg_t pin_cfg [2];

  // Channel registers
  acg_chan_cfg_t chan_cfg [NUM_CH];
  logic [NUM_CH-1:0] chan_en;

  // Register decode
  logic wr_pin_ctrl;
  logic [NUM_CH-1:0] wr_chan;
  logic [ACG_DATA_W-1:0] next_rdata;
  logic [ACG_DATA_W-1:0] pin_ctrl_view;
  logic [1:0] pin_readback;

  // Sequencer
  logic [ACG_CH_IDX_W-1:0] cur_ch;
  logic [ACG_CH_IDX_W-1:0] next_ch;
  logic any_enabled;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reset_meta_n <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta_n <= 1'b1;
      reset_sync_n <= reset_meta_n;
    end
  end

  // Write decode; the identifier offset has no write path
  assign wr_pin_ctrl = reg_write_i && (reg_addr_i == ACG_OFS_PIN_CTRL);

  // One control slice per general pin. Each field of pin 1 sits one
  // bit above the same field of pin 0, so the pin index is added to
  // the pin 0 position. All three bits of both pins load in the same
  // write, which keeps enable and level consistent at the pad: there
  // is no cycle in which a new enable meets an old level.
  for (genvar gp = 0; gp < 2; gp++) begin : g_pin
    always_ff @(posedge clk_i or negedge reset_sync_n) begin
      if (!reset_sync_n) begin
        pin_cfg[gp] <= '0;
      end else if (wr_pin_ctrl) begin
        pin_cfg[gp].input_enable <=
          reg_wdata_i[ACG_POS_PIN0_IN_EN + gp];
        pin_cfg[gp].output_enable <=
          reg_wdata_i[ACG_POS_PIN0_OUT_EN + gp];
        pin_cfg[gp].level <=
          reg_wdata_i[ACG_POS_PIN0_LEVEL + gp];
      end
    end
  end

  // Pin drivers come straight from register flops, so no glitches
  // reach the pad when unrelated bits of the register are written
  always_comb begin
    general_pin_out_o[1] = pin_cfg[1].level;
    general_pin_out_o[0] = pin_cfg[0].level;
    general_pin_oe_n_o[1] = ~pin_cfg[1].output_enable;
    general_pin_oe_n_o[0] = ~pin_cfg[0].output_enable;
  end

  // Readback of the level bits: the pad when it is an input, else
  // the stored write data. With both enables set the pad wins, so a
  // host can see contention on its own output.
  always_comb begin
    pin_readback[1] = pin_cfg[1].input_enable ? general_pin_in_i[1]
                                              : pin_cfg[1].level;
    pin_readback[0] = pin_cfg[0].input_enable ? general_pin_in_i[0]
                                              : pin_cfg[0].level;
  end

  // Assemble the pin control register view; upper bits read zero
  always_comb begin
    pin_ctrl_view = '0;
    pin_ctrl_view[ACG_POS_PIN1_IN_EN] = pin_cfg[1].input_enable;
    pin_ctrl_view[ACG_POS_PIN0_IN_EN] = pin_cfg[0].input_enable;
    pin_ctrl_view[ACG_POS_PIN1_OUT_EN] = pin_cfg[1].output_enable;
    pin_ctrl_view[ACG_POS_PIN0_OUT_EN] = pin_cfg[0].output_enable;
    pin_ctrl_view[ACG_POS_PIN1_LEVEL] = pin_readback[1];
    pin_ctrl_view[ACG_POS_PIN0_LEVEL] = pin_readback[0];
  end

  // One channel register per index; reserved bits never store
  for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_chan
    assign wr_chan[gi] = reg_write_i &&
      (reg_addr_i == ACG_OFS_CH_FIRST + ACG_ADDR_W'(gi));
    assign chan_en[gi] = chan_cfg[gi].channel_enable;

    always_ff @(posedge clk_i or negedge reset_sync_n) begin
      if (!reset_sync_n) begin
        chan_cfg[gi] <= acg_chan_cfg_t'(ACG_RST_CHANNEL);
      end else if (wr_chan[gi]) begin
        chan_cfg[gi].channel_enable <=
          reg_wdata_i[ACG_POS_CH_ENABLE];
        chan_cfg[gi].setup_select <=
          reg_wdata_i[ACG_POS_SETUP_HI:ACG_POS_SETUP_LO];
        chan_cfg[gi].reserved <= 2'h0;
        chan_cfg[gi].input_pair_select <=
          reg_wdata_i[ACG_POS_PAIR_HI:ACG_POS_PAIR_LO];
      end
    end
  end

  assign channel_enable_o = chan_en;

  // Read multiplexer; unmapped offsets read zero. The channel index
  // is taken from the low address bits only after the range test, so
  // an unmapped offset can never alias onto a channel register.
  always_comb begin
    next_rdata = '0;
    if (reg_addr_i == ACG_OFS_PIN_CTRL) begin
      next_rdata = pin_ctrl_view;
    end else if (reg_addr_i == ACG_OFS_IDENT) begin
      next_rdata = IDENT_CODE;
    end else if (reg_addr_i >= ACG_OFS_CH_FIRST &&
                 reg_addr_i <= ACG_OFS_CH_LAST) begin
      next_rdata = chan_cfg[reg_addr_i[ACG_CH_IDX_W-1:0]];
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk_i or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      reg_rdata_o <= '0;
    end else if (reg_read_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // Search upward from the current channel, wrapping, for the next
  // enabled one; the current channel itself is the last candidate.
  // The search is a flat priority chain of NUM_CH steps: cheap for
  // sixteen channels, but its depth grows linearly with NUM_CH.
  always_comb begin
    logic [ACG_CH_IDX_W-1:0] cand;
    logic found;
    cand = '0;
    found = 1'b0;
    next_ch = cur_ch;
    for (int k = 1; k <= NUM_CH; k++) begin
      cand = cur_ch + ACG_CH_IDX_W'(k);
      if (!found && chan_en[cand]) begin
        next_ch = cand;
        found = 1'b1;
      end
    end
  end

  assign any_enabled = |chan_en;

  // Advance on each finished conversion, and leave a channel that
  // software has just disabled without waiting for the engine
  always_ff @(posedge clk_i or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      cur_ch <= '0;
    end else if (any_enabled &&
                 (conv_done_i || !chan_en[cur_ch])) begin
      cur_ch <= next_ch;
    end
  end

  // Selection handed to the engine. The engine loads the setup,
  // filter, offset and gain registers of the chosen setup as one set;
  // channels share a setup whenever their codes are equal, as all are at setup 0 after reset.
  always_comb begin
    conv_sel_o.valid = chan_en[cur_ch];
    conv_sel_o.channel = cur_ch;
    conv_sel_o.setup_select = chan_cfg[cur_ch].setup_select;
    conv_sel_o.input_pair_select =
      chan_cfg[cur_ch].input_pair_select;
  end

endmodule

// File: acg_regs_chk.sv
// Checker: port-level properties of the register bank
module acg_regs_chk #(
  parameter int NUM_CH = 16
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [1:0] general_pin_out_o,
  input wire logic [1:0] general_pin_oe_n_o,
  input wire logic conv_done_i,
  input wire acg_pkg::acg_conv_sel_t conv_sel_o,
  input wire logic [NUM_CH-1:0] channel_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import acg_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Write to pin control, write to any channel
  sequence s_pin_wr;
    reg_write_i && reg_addr_i == 8'h06;
  endsequence
  sequence s_ch_wr;
    reg_write_i && reg_addr_i[7:4] == 4'h1;
  endsequence
  chk_pin_drive:
    assert property (s_pin_wr |=>
      general_pin_oe_n_o == ~$past(reg_wdata_i[3:2])) else $error("oe");
  chk_pin_level:
    assert property (s_pin_wr |=>
      general_pin_out_o == $past(reg_wdata_i[1:0])) else $error("level");
  chk_ident_read:
    assert property (reg_read_i && reg_addr_i == 8'h07 |=>
      reg_rdata_o[15:4] == ACG_IDENT_DEFAULT[15:4]) else $error("ident");
  chk_rdata_idle:
    assert property (!reg_read_i |=> reg_rdata_o == 16'h0000)
      else $error("rdata");
  chk_ch_enable:
    assert property (s_ch_wr |=> channel_enable_o[$past(reg_addr_i[3:0])]
      == $past(reg_wdata_i[15])) else $error("enable");
  chk_sel_fields:
    assert property (s_ch_wr ##0 (reg_addr_i[3:0] == conv_sel_o.channel
      && reg_wdata_i[15] && conv_sel_o.valid && !conv_done_i) |=>
      {conv_sel_o.setup_select, conv_sel_o.input_pair_select} ==
      {$past(reg_wdata_i[14:12]), $past(reg_wdata_i[9:0])})
      else $error("fields");
  chk_sel_valid:
    assert property (conv_sel_o.valid ==
      channel_enable_o[conv_sel_o.channel]) else $error("valid");
  chk_seq_step:
    assert property (conv_done_i && !reg_write_i && conv_sel_o.valid &&
      $countones(channel_enable_o) > 1 |=>
      conv_sel_o.channel != $past(conv_sel_o.channel)) else $error("step");
  chk_seq_hold:
    assert property (conv_done_i && !reg_write_i && conv_sel_o.valid &&
      $countones(channel_enable_o) == 1 |=> $stable(conv_sel_o.channel))
      else $error("hold");
endmodule

bind acg_regs acg_regs_chk #(.NUM_CH(NUM_CH)) i_acg_regs_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .general_pin_out_o(general_pin_out_o),
  .general_pin_oe_n_o(general_pin_oe_n_o), .conv_done_i(conv_done_i),
  .conv_sel_o(conv_sel_o), .channel_enable_o(channel_enable_o));

// File: acg_regs_tb_top.sv
// Testbench: register access sequences against expected values
module acg_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import acg_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic done = 1'b0;
  logic [1:0] ext = 2'b00;
  logic [15:0] rdata, ch_en, v;
  logic [1:0] pin_out, oe_n, pad;
  acg_conv_sel_t sel;
  int bad_count = 0;
  int num_checks = 0;
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  acg_regs i_acg_regs (.clk_i(clk), .reset_n_i(reset_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_write_i(wr_en), .reg_read_i(rd_en),
    .reg_rdata_o(rdata), .general_pin_in_i(pad), .general_pin_out_o(pin_out),
    .general_pin_oe_n_o(oe_n), .conv_done_i(done), .conv_sel_o(sel),
    .channel_enable_o(ch_en));
  acg_pad_model i_acg_pad_model (.oe_n_i(oe_n), .out_i(pin_out),
    .ext_i(ext), .pad_o(pad));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus cycles; data is sampled once the taking edge has landed
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk) wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) addr <= a; rd_en <= 1'b1;
    @(posedge clk) rd_en <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic step();
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    #1;
  endtask
  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      rd(8'h10 + 8'(i)); check(v, 16'h8001);
    end
    check(ch_en, 16'hFFFF);
    rd(8'h06); check(v, 16'h0000);
    check({14'h0000, oe_n}, 16'h0003);
    // Read-only identifier ignores writes; unmapped reads give zero
    rd(8'h07);
    check({v[15:4], 4'h0}, {ACG_IDENT_DEFAULT[15:4], 4'h0});
    wr(8'h07, 16'h0000);
    rd(8'h07);
    check({v[15:4], 4'h0}, {ACG_IDENT_DEFAULT[15:4], 4'h0});
    rd(8'h20); check(v, 16'h0000);
    // Both pins driven, then both sensed with reserved bits set
    wr(8'h06, 16'h000E);
    check({14'h0000, pin_out}, 16'h0002);
    check({14'h0000, oe_n}, 16'h0000);
    rd(8'h06); check(v, 16'h000E);
    @(posedge clk) ext <= 2'b01;
    wr(8'h06, 16'hFFF0);
    check({14'h0000, oe_n}, 16'h0003);
    rd(8'h06); check(v, 16'h0031);
    // Every setup code; reserved bits must be dropped
    for (int s = 0; s < 8; s++) begin
      wr(8'h10 + 8'(s), {1'b1, 3'(s), 2'b11, 10'h010});
      rd(8'h10 + 8'(s)); check(v, {1'b1, 3'(s), 12'h010});
    end
    for (int i = 1; i < 16; i++) begin
      wr(8'h10 + 8'(i), 16'h0001);
    end
    check(ch_en, 16'h0001);
    step(); check({12'h000, sel.channel}, 16'h0000);
    check({6'h00, sel.input_pair_select}, 16'h0010);
    wr(8'h13, 16'h8001); // same setup as channel 0
    step(); check({12'h000, sel.channel}, 16'h0003);
    check({6'h00, sel.input_pair_select}, 16'h0001);
    check({13'h0000, sel.setup_select}, 16'h0000);
    step(); check({12'h000, sel.channel}, 16'h0000);
    wr(8'h10, 16'h0000);
    wr(8'h13, 16'h0000);
    check({15'h0000, sel.valid}, 16'h0000);
    complete_run();
  end
endmodule
